// ==== common/pseq_pkg.sv ====
// Purpose: shared constants and types of the six rail power sequencer
// Assumes: 125 MHz system clock, classic Wishbone register access
// Notes: byte addresses, field positions, reset values and timing counts

`default_nettype none

package pseq_pkg;

  // ****************************************************************
  // channel count and timing
  // ****************************************************************
  localparam int unsigned NCH = 6;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_NS = 8;
  // delay tick is one millisecond, given in ns
  localparam int unsigned TICK_NS = 1_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned BAUD = 115200;
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD;
  localparam logic [10:0] BAUD_CNT = 11'(BAUD_DIV - 1);
  // start, eight data, one stop, no parity
  localparam logic [3:0] UART_BITS = 4'hA;

  // ****************************************************************
  // register map (byte addresses and word indices)
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_ISTAT = 8'h08;
  localparam logic [7:0] ADR_IMASK = 8'h0C;
  // stored delays: on 0..5 then off 0..5, one word each from 0x10
  localparam logic [5:0] WIDX_STO = 6'h04;
  // active delays, same order, read only, from 0x40
  localparam logic [5:0] WIDX_ACT = 6'h10;
  localparam logic [5:0] WIDX_END = 6'h1C;
  localparam logic [5:0] NDLY = 6'h0C;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int unsigned CTRL_LOG = 0;
  localparam int unsigned ST_SUP = 6;
  localparam int unsigned ST_GOOD = 8;
  localparam int unsigned ST_STATE = 16;
  localparam int unsigned IRQ_STEP = 0;
  localparam int unsigned IRQ_UP = 1;
  localparam int unsigned IRQ_DOWN = 2;
  localparam int unsigned IRQ_LOSS = 3;
  localparam int unsigned NIRQ = 4;
  localparam logic [15:0] DLY_RST = 16'h000A;
  localparam logic [7:0] LOG_SYNC = 8'hA5;
  localparam logic [2:0] LOG_LAST = 3'h6;

  typedef enum logic [2:0] {
    S_OFF,
    S_UP_DLY,
    S_UP_WAIT,
    S_ON,
    S_DN_WAIT,
    S_DN_DLY
  } pseq_state_e;

  typedef logic [15:0] pseq_dly_t;

endpackage : pseq_pkg

`default_nettype wire

// ==== common/pseq_tx_if.sv ====
// Purpose: byte stream from the sequencer core to its serial transmitter
// Assumes: both ends on the system clock
// Notes: a byte moves when valid and ready are both high

`timescale 1ns/1ps
`default_nettype none

interface pseq_tx_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : pseq_tx_if

`default_nettype wire

// ==== logic/pseq_uart_tx.sv ====
// Purpose: serial transmitter, 8 data bits, one stop bit, no parity
// Assumes: bit time is a fixed count of system clocks
// Notes: line idles high; ready only while no frame is on the line

`timescale 1ns/1ps
`default_nettype none

module pseq_uart_tx (
  input wire logic clk_i,
  input wire logic resetn_i,
  pseq_tx_if.snk tx,
  output logic uart_tx_o
);

  logic [10:0] div_q;
  logic [3:0] bits_q;
  logic [9:0] sh_q;

  // ****************************************************************
  // handshake and bit timing
  // ****************************************************************
  wire start_w = tx.valid && tx.ready;
  wire bit_end_w = (div_q == 11'h000);
  assign tx.ready = (bits_q == 4'h0);
  assign uart_tx_o = sh_q[0];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 11'h000;
      bits_q <= 4'h0;
      sh_q <= 10'h3FF;
    end else if (start_w) begin
      sh_q <= {1'b1, tx.data, 1'b0};
      bits_q <= pseq_pkg::UART_BITS;
      div_q <= pseq_pkg::BAUD_CNT;
    end else if (bits_q != 4'h0) begin
      if (bit_end_w) begin
        sh_q <= {1'b1, sh_q[9:1]};
        bits_q <= bits_q - 4'h1;
        div_q <= pseq_pkg::BAUD_CNT;
      end else begin
        div_q <= div_q - 11'h001;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_baud_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    (bits_q != 4'h0 && !bit_end_w) |=> $stable(uart_tx_o);
  endproperty
  a_baud_hold: assert property (p_baud_hold) else $error("line moved inside a bit");

  property p_start_bit;
    @(posedge clk_i) disable iff (!resetn_i)
    start_w |=> (!uart_tx_o) [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit missing");

endmodule : pseq_uart_tx

`default_nettype wire

// ==== logic/pseq_top.sv ====
// Purpose: six rail power sequencer with Wishbone registers and log stream
// Assumes: supply sense and rail good come from pins, levels from an ADC
// Notes: delays count in millisecond ticks, loaded at each step start
// Notes on behaviour
// - supply present, wait first delay, enable lowest
// - rail good rise starts next on-delay
// - enable rails strictly in ascending order
// - keep watching supply once all rails up
// - supply lost disables highest rail first
// - rail good fall starts next off-delay
// - disable rails in exact reverse order
// - each up step and each down step after the first has own delay
// - delays are 1 to 65535, sixteen bits
// - new delays stored, used after power cycle
// - active delays readable by the host
// - serial link is 115200 baud 8N1
// - logging streams every rail level repeatedly

`timescale 1ns/1ps
`default_nettype none

module pseq_top #(
  parameter int unsigned TICK_CYCLES = pseq_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic input_supply_ok_i,
  input wire logic [5:0] rail_good_i,
  input wire logic [47:0] rail_level_i,
  output logic [5:0] rail_en_o,
  output logic uart_tx_o,
  output logic irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  pseq_pkg::pseq_state_e st_q, st_d;
  logic [2:0] idx_q, idx_d;
  pseq_pkg::pseq_dly_t cnt_q, cnt_d;
  logic [5:0] en_q, en_d;
  logic load_act;
  logic restart;
  logic [31:0] tick_q;
  logic [6:0] sync1_q, sync2_q;
  logic [5:0] good_p_q;
  logic sup_p_q;
  pseq_pkg::pseq_dly_t sto_q [12];
  pseq_pkg::pseq_dly_t act_q [12];
  logic log_en_q;
  logic [3:0] ist_q, imask_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [2:0] lseq_q;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // two flops for supply sense and rail good before any use
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {input_supply_ok_i, rail_good_i};
      sync2_q <= sync1_q;
    end
  end

  wire sup_w = sync2_q[6];
  wire [5:0] good_w = sync2_q[5:0];

  // edge history of the synchronised pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      good_p_q <= 6'h00;
      sup_p_q <= 1'b0;
    end else begin
      good_p_q <= good_w;
      sup_p_q <= sup_w;
    end
  end

  wire [5:0] good_rise_w = good_w & ~good_p_q;
  wire sup_fall_w = sup_p_q & ~sup_w;

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  // tick restarts with each delay
  wire tick_w = (tick_q == TICK_CYCLES - 1);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_q <= 32'h0000_0000;
    end else if (restart || tick_w) begin
      tick_q <= 32'h0000_0000;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // sequence control
  // ****************************************************************
  // highest rail currently enabled
  function automatic logic [2:0] top_rail(input logic [5:0] en);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (en[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : top_rail

  wire [2:0] top_w = top_rail(en_q);
  wire [2:0] idx_up_w = idx_q + 3'h1;
  wire [2:0] idx_dn_w = idx_q - 3'h1;
  wire [3:0] off_sel_w = {1'b0, idx_q} + 4'h5;
  wire cnt_last_w = (cnt_q == 16'h0001);

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    en_d = en_q;
    load_act = 1'b0;
    restart = 1'b0;
    case (st_q)
      pseq_pkg::S_OFF: begin
        if (sup_w) begin
          idx_d = 3'h0;
          cnt_d = act_q[0];
          restart = 1'b1;
          st_d = pseq_pkg::S_UP_DLY;
        end
      end
      pseq_pkg::S_UP_DLY, pseq_pkg::S_UP_WAIT, pseq_pkg::S_ON: begin
        if (!sup_w) begin
          if (en_q != 6'h00) begin
            en_d[top_w] = 1'b0;
            idx_d = top_w;
            st_d = pseq_pkg::S_DN_WAIT;
          end else begin
            load_act = 1'b1;
            st_d = pseq_pkg::S_OFF;
          end
        end else if (st_q == pseq_pkg::S_UP_DLY) begin
          if (tick_w) begin
            if (cnt_last_w) begin
              en_d[idx_q] = 1'b1;
              st_d = pseq_pkg::S_UP_WAIT;
            end else begin
              cnt_d = cnt_q - 16'h0001;
            end
          end
        end else if (st_q == pseq_pkg::S_UP_WAIT) begin
          // rail good rise starts next delay
          // next rail up only after this one
          if (good_rise_w[idx_q]) begin
            if (idx_q == 3'h5) begin
              st_d = pseq_pkg::S_ON;
            end else begin
              idx_d = idx_up_w;
              cnt_d = act_q[idx_up_w];
              restart = 1'b1;
              st_d = pseq_pkg::S_UP_DLY;
            end
          end
        end
      end
      pseq_pkg::S_DN_WAIT: begin
        // rail good low starts next off-delay
        // walk down to the lowest rail
        if (!good_w[idx_q]) begin
          if (idx_q == 3'h0) begin
            load_act = 1'b1;
            st_d = pseq_pkg::S_OFF;
          end else begin
            idx_d = idx_dn_w;
            cnt_d = act_q[off_sel_w];
            restart = 1'b1;
            st_d = pseq_pkg::S_DN_DLY;
          end
        end
      end
      pseq_pkg::S_DN_DLY: begin
        if (tick_w) begin
          if (cnt_last_w) begin
            en_d[idx_q] = 1'b0;
            st_d = pseq_pkg::S_DN_WAIT;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      end
      default: begin
        en_d = 6'h00;
        st_d = pseq_pkg::S_OFF;
      end
    endcase
  end

  // sequence registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= pseq_pkg::S_OFF;
      idx_q <= 3'h0;
      cnt_q <= 16'h0000;
      en_q <= 6'h00;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end

  assign rail_en_o = en_q;

  // ****************************************************************
  // Wishbone slave decode
  // ****************************************************************
  wire req_w = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr_w = req_w && wb_we_i;
  wire [5:0] widx_w = wb_adr_i[7:2];
  wire [5:0] sto_k_w = widx_w - pseq_pkg::WIDX_STO;
  wire [5:0] act_k_w = widx_w - pseq_pkg::WIDX_ACT;
  wire hit_sto_w = (widx_w >= pseq_pkg::WIDX_STO) && (widx_w < pseq_pkg::WIDX_ACT);
  wire hit_act_w = (widx_w >= pseq_pkg::WIDX_ACT) && (widx_w < pseq_pkg::WIDX_END);
  wire wr_ctrl_w = wr_w && wb_sel_i[0] && (wb_adr_i == pseq_pkg::ADR_CTRL);
  wire wr_istat_w = wr_w && wb_sel_i[0] && (wb_adr_i == pseq_pkg::ADR_ISTAT);
  wire wr_imask_w = wr_w && wb_sel_i[0] && (wb_adr_i == pseq_pkg::ADR_IMASK);
  wire [15:0] dat16_w = wb_dat_i[15:0];
  wire [15:0] old16_w = sto_q[sto_k_w[3:0]];
  wire [15:0] new16_w = {wb_sel_i[1] ? dat16_w[15:8] : old16_w[15:8],
                         wb_sel_i[0] ? dat16_w[7:0] : old16_w[7:0]};
  // zero is out of range and ignored
  wire wr_sto_w = wr_w && hit_sto_w && (wb_sel_i[1:0] != 2'b00) && (new16_w != 16'h0000);

  wire [31:0] status_w = {13'h0000, st_q, 2'b00, good_w, 1'b0, sup_w, en_q};
  wire [31:0] rd_w = (wb_adr_i == pseq_pkg::ADR_CTRL) ? {31'h0, log_en_q} :
                     (wb_adr_i == pseq_pkg::ADR_STATUS) ? status_w :
                     (wb_adr_i == pseq_pkg::ADR_ISTAT) ? {28'h0, ist_q} :
                     (wb_adr_i == pseq_pkg::ADR_IMASK) ? {28'h0, imask_q} :
                     hit_sto_w ? {16'h0000, sto_q[sto_k_w[3:0]]} :
                     hit_act_w ? {16'h0000, act_q[act_k_w[3:0]]} :
                     32'h0000_0000;

  // one wait state answer, ack drops the cycle after
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_w;
      dat_q <= (req_w && !wb_we_i) ? rd_w : dat_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************************************
  // delay settings
  // ****************************************************************
  // one stored and one active word per step
  // active copy refreshed only at power-off
  // active copy readable at any time
  for (genvar k = 0; k < 12; k++) begin : g_dly
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        sto_q[k] <= pseq_pkg::DLY_RST;
        act_q[k] <= pseq_pkg::DLY_RST;
      end else begin
        if (wr_sto_w && (sto_k_w == 6'(k))) begin
          sto_q[k] <= new16_w;
        end
        if (load_act) begin
          act_q[k] <= sto_q[k];
        end
      end
    end
  end

  // ****************************************************************
  // control and interrupts
  // ****************************************************************
  wire [3:0] ev_w = {sup_fall_w,
                     load_act,
                     (st_d == pseq_pkg::S_ON) && (st_q != pseq_pkg::S_ON),
                     en_d != en_q};
  wire [3:0] w1c_w = wr_istat_w ? wb_dat_i[3:0] : 4'h0;

  // set wins over a same-cycle clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ist_q <= 4'h0;
      imask_q <= 4'h0;
      log_en_q <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~w1c_w) | ev_w;
      imask_q <= wr_imask_w ? wb_dat_i[3:0] : imask_q;
      log_en_q <= wr_ctrl_w ? wb_dat_i[pseq_pkg::CTRL_LOG] : log_en_q;
    end
  end

  assign irq_o = |(ist_q & imask_q);

  // ****************************************************************
  // level logging stream
  // ****************************************************************
  pseq_tx_if tx_if ();

  // sync byte then six rail levels, repeated
  assign tx_if.valid = log_en_q;
  assign tx_if.data = (lseq_q == 3'h0) ? pseq_pkg::LOG_SYNC :
                      rail_level_i[8 * (lseq_q - 3'h1) +: 8];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lseq_q <= 3'h0;
    end else if (!log_en_q) begin
      lseq_q <= 3'h0;
    end else if (tx_if.ready) begin
      lseq_q <= (lseq_q == pseq_pkg::LOG_LAST) ? 3'h0 : lseq_q + 3'h1;
    end
  end

  pseq_uart_tx u_tx (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tx(tx_if),
    .uart_tx_o(uart_tx_o)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_rail_a_up;
    (st_q == pseq_pkg::S_UP_DLY) && (idx_q == 3'h0) && sup_w && tick_w && cnt_last_w;
  endsequence

  sequence s_loss_on;
    (st_q == pseq_pkg::S_ON) && !sup_w;
  endsequence

  property p_first_delay;
    (st_q == pseq_pkg::S_OFF) && sup_w |=>
      (st_q == pseq_pkg::S_UP_DLY) && (cnt_q == act_q[0]) && (en_q == 6'h00);
  endproperty
  a_first_delay: assert property (p_first_delay) else $error("first delay not loaded");

  property p_rail_a_on;
    s_rail_a_up |=> en_q[0] && (st_q == pseq_pkg::S_UP_WAIT);
  endproperty
  a_rail_a_on: assert property (p_rail_a_on) else $error("lowest rail not enabled");

  property p_next_delay;
    (st_q == pseq_pkg::S_UP_WAIT) && sup_w && good_rise_w[idx_q] && (idx_q != 3'h5) |=>
      (st_q == pseq_pkg::S_UP_DLY) && (idx_q == $past(idx_up_w));
  endproperty
  a_next_delay: assert property (p_next_delay) else $error("next up delay not started");

  property p_order;
    (en_q & (en_q + 6'h01)) == 6'h00;
  endproperty
  a_order: assert property (p_order) else $error("rail enables out of order");

  property p_loss_top;
    s_loss_on |=> (st_q == pseq_pkg::S_DN_WAIT) && (idx_q == 3'h5) && (en_q == 6'h1F);
  endproperty
  a_loss_top: assert property (p_loss_top) else $error("highest rail not first off");

  property p_off_delay;
    (st_q == pseq_pkg::S_DN_WAIT) && !good_w[idx_q] && (idx_q != 3'h0) |=>
      (st_q == pseq_pkg::S_DN_DLY) && (cnt_q == act_q[$past(off_sel_w)]);
  endproperty
  a_off_delay: assert property (p_off_delay) else $error("off delay not loaded");

  property p_store;
    wr_sto_w && (sto_k_w == 6'h00) && (wb_sel_i[1:0] == 2'b11) |=> sto_q[0] == $past(dat16_w);
  endproperty
  a_store: assert property (p_store) else $error("delay write lost");

  property p_active_held;
    (st_q != pseq_pkg::S_OFF) && !load_act |=> $stable(act_q[0]) && $stable(act_q[6]);
  endproperty
  a_active_held: assert property (p_active_held) else $error("active delay changed");

  property p_tick_hold;
    (st_q == pseq_pkg::S_UP_DLY) && sup_w && !tick_w |=> $stable(cnt_q) && $stable(en_q);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("delay moved without tick");

  property p_abort_up;
    (st_q == pseq_pkg::S_UP_WAIT) && !sup_w |=>
      (st_q == pseq_pkg::S_DN_WAIT) && !en_q[idx_q];
  endproperty
  a_abort_up: assert property (p_abort_up) else $error("power-up not abandoned");

  // an idle line stays idle and high while logging is off
  property p_log_gate;
    !log_en_q && tx_if.ready |=> tx_if.ready && uart_tx_o;
  endproperty
  a_log_gate: assert property (p_log_gate) else $error("log byte while disabled");

  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

endmodule : pseq_top

`default_nettype wire

// ==== verification/pseq_reg_model.sv ====
// Purpose: six regulator stand-ins, each with enable in and rail good out
// Assumes: one system clock drives the model
// Notes: rail good follows its enable LAG+1 clocks after the enable changes, both ways

`timescale 1ns/1ps
`default_nettype none

module pseq_reg_model #(
  parameter int unsigned LAG = 20
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [5:0] en_i,
  output logic [5:0] good_o
);
  logic [7:0] cnt_q [6];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      good_o <= 6'h00;
      for (int k = 0; k < 6; k++) cnt_q[k] <= 8'h00;
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (en_i[k] == good_o[k]) begin
          cnt_q[k] <= 8'h00;
        end else if (cnt_q[k] == 8'(LAG)) begin
          good_o[k] <= en_i[k];
        end else begin
          cnt_q[k] <= cnt_q[k] + 8'h01;
        end
      end
    end
  end
endmodule : pseq_reg_model

`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench of the power sequencer
// Assumes: tick shortened to 10 clocks, regulators modelled
// Notes: rails, serial log and registers are judged at the pins

`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int TK = 10;
  localparam int BIT = 1085;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic sup = 1'b0;
  logic [31:0] rdat;
  logic [7:0] b;
  logic [5:0] good;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] rail_en_o;
  logic uart_tx_o;
  logic irq_o;
  int miscompares = 0;
  int compares = 0;

  pseq_top #(.TICK_CYCLES(TK)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_supply_ok_i(sup),
    .rail_good_i(good), .rail_level_i(48'h605040302017), .rail_en_o(rail_en_o),
    .uart_tx_o(uart_tx_o), .irq_o(irq_o));
  pseq_reg_model regs (.clk_i(clk_i), .resetn_i(resetn_i), .en_i(rail_en_o), .good_o(good));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // classic cycle, held until ack is sampled at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk("wb ack drop", 32'h0, 32'(wb_ack_o));
  endtask : wb

  task automatic wait_en(input logic [5:0] e);
    logic [5:0] c;
    int n;
    c = rail_en_o;
    n = 0;
    while (rail_en_o === c && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk("rail_en", 32'(e), 32'(rail_en_o));
  endtask : wait_en

  // one serial frame, sampled mid-bit
  task automatic rx();
    int n;
    n = 0;
    while (uart_tx_o !== 1'b0 && n < 30000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (BIT / 2) @(negedge clk_i);
    chk("start bit", 32'h0, 32'(uart_tx_o));
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clk_i);
      b[i] = uart_tx_o;
    end
    repeat (BIT) @(negedge clk_i);
    chk("stop bit", 32'h1, 32'(uart_tx_o));
  endtask : rx

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_regs();
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk("zero write", 32'hA, rdat);
    wb(1'b1, 8'h10, 32'hFFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk("max delay", 32'hFFFF, rdat);
    wb(1'b1, 8'h10, 32'h5);
    wb(1'b1, 8'h40, 32'h7);
    wb(1'b0, 8'h40, 32'h0);
    chk("active on0", 32'hA, rdat);
    wb(1'b0, 8'h7C, 32'h0);
    chk("unmapped", 32'h0, rdat);
    for (int k = 1; k < 12; k++) begin
      wb(1'b1, 8'(16 + 4 * k), 32'(k + 3));
      wb(1'b0, 8'(16 + 4 * k), 32'h0);
      chk("stored delay", 32'(k + 3), rdat);
    end
  endtask : s_regs

  task automatic s_up(input int d, input int m);
    int n;
    n = 0;
    @(posedge clk_i);
    sup <= 1'b1;
    while (rail_en_o[0] !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk("first delay", 32'h1, 32'(n >= d * TK && n <= d * TK + 12));
    chk("rail_en", 32'h1, 32'(rail_en_o));
    for (int k = 2; k <= m; k++) wait_en(6'((1 << k) - 1));
  endtask : s_up

  task automatic s_irq();
    // let the top rail's good pass its lag and the synchroniser
    repeat (40) @(posedge clk_i);
    wb(1'b0, pseq_pkg::ADR_STATUS, 32'h0);
    chk("status", 32'h33F7F, rdat & 32'h73F7F);
    wb(1'b0, pseq_pkg::ADR_ISTAT, 32'h0);
    chk("all up flag", 32'h2, rdat & 32'h2);
    @(negedge clk_i);
    chk("irq masked", 32'h0, 32'(irq_o));
    wb(1'b1, pseq_pkg::ADR_IMASK, 32'h2);
    @(negedge clk_i);
    chk("irq", 32'h1, 32'(irq_o));
    wb(1'b1, pseq_pkg::ADR_ISTAT, 32'h2);
    @(negedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
  endtask : s_irq

  task automatic s_log();
    wb(1'b1, pseq_pkg::ADR_CTRL, 32'h1);
    rx();
    chk("sync byte", 32'hA5, 32'(b));
    rx();
    chk("rail0 level", 32'h17, 32'(b));
    wb(1'b1, pseq_pkg::ADR_CTRL, 32'h0);
  endtask : s_log

  task automatic s_down();
    @(posedge clk_i);
    sup <= 1'b0;
    for (int k = 5; k >= 0; k--) wait_en(6'((1 << k) - 1));
    // power-down ends only once the lowest rail's good has fallen
    repeat (40) @(posedge clk_i);
    wb(1'b0, 8'h40, 32'h0);
    chk("active after cycle", 32'h5, rdat);
    wb(1'b0, pseq_pkg::ADR_ISTAT, 32'h0);
    chk("down flags", 32'hC, rdat & 32'hC);
  endtask : s_down

  // supply lost with two rails up
  task automatic s_abort();
    s_up(5, 2);
    @(posedge clk_i);
    sup <= 1'b0;
    wait_en(6'h01);
    wait_en(6'h00);
  endtask : s_abort

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("reset rail_en", 32'h0, 32'(rail_en_o));
    chk("reset line", 32'h1, 32'(uart_tx_o));
    chk("reset irq", 32'h0, 32'(irq_o));
    s_regs();
    s_up(10, 6);
    s_irq();
    s_log();
    s_down();
    s_abort();
    results();
  end

  // hang guard, well past the expected run of about 23k cycles
  initial begin
    #(60_000 * 8);
    miscompares++;
    results();
  end
endmodule : tb_top

`default_nettype wire
